/* hdl/cppt_pkg.sv */
// Package for the calendar periodic pulse timer: offsets, field layout,
// reset values, cycle counts and the carrier types.
// Assumes a 50 MHz system clock and a calendar source on that same clock.
package cppt_pkg;

  // Clock and machine cycle lengths
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned MC_Q_MS      = 250;
  localparam int unsigned MC_H_MS      = 500;
  localparam int unsigned MC_F_MS      = 1000;
  localparam int unsigned MC_Q_CYC     = (CLK_HZ / 1000) * MC_Q_MS;
  localparam int unsigned MC_H_CYC     = (CLK_HZ / 1000) * MC_H_MS;
  localparam int unsigned MC_F_CYC     = (CLK_HZ / 1000) * MC_F_MS;

  // Register offsets
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_PERIOD  = 8'h04;
  localparam logic [7:0]  ADDR_START   = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0C;

  // Field positions
  localparam int unsigned HOUR_LSB     = 0;
  localparam int unsigned MIN_LSB      = 8;
  localparam int unsigned SEC_LSB      = 16;
  localparam int unsigned DAY_LSB      = 24;
  localparam int unsigned FMT_LSB      = 0;
  localparam int unsigned MCSEL_LSB    = 2;
  localparam int unsigned HOLD_BIT     = 4;
  localparam int unsigned ERR_BIT      = 0;
  localparam int unsigned OUT_BIT      = 1;
  localparam int unsigned PHASE_LSB    = 4;

  // Ranges and weights
  localparam logic [4:0]  HOUR_MAX     = 5'h17;
  localparam logic [5:0]  MIN_MAX      = 6'h3B;
  localparam logic [5:0]  SEC_MAX      = 6'h3B;
  localparam logic [4:0]  DAY_MIN      = 5'h01;
  localparam logic [4:0]  DAY_MAX      = 5'h1F;
  localparam logic [16:0] SEC_PER_HOUR = 17'h00E10;
  localparam logic [16:0] SEC_PER_MIN  = 17'h0003C;

  // Values after reset
  localparam logic [4:0]  DAY_RST      = 5'h01;
  localparam logic [1:0]  MCSEL_RST    = 2'h2;

  typedef enum logic [1:0] {
    CPPT_FMT_NONE,
    CPPT_FMT_DAILY,
    CPPT_FMT_WEEKLY,
    CPPT_FMT_MONTHLY
  } cppt_fmt_t;

  typedef enum logic [1:0] {
    CPPT_PH_IDLE,
    CPPT_PH_ARM,
    CPPT_PH_TO_START,
    CPPT_PH_REPEAT
  } cppt_phase_t;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } cppt_hms_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cppt_bus_t;

  // Wall time: wday 1 = Monday .. 7 = Sunday; mdays = length of this month
  typedef struct packed {
    cppt_hms_t  tod;
    logic [2:0] wday;
    logic [4:0] mday;
    logic [4:0] mdays;
    logic       sec_tick;
  } cppt_cal_t;

  typedef struct packed {
    cppt_fmt_t   fmt;
    logic [1:0]  mc_sel;
    logic        hold;
    cppt_hms_t   per;
    logic [16:0] per_sec;
    cppt_hms_t   st;
    logic [4:0]  st_day;
    logic [16:0] st_sec;
    logic        err;
    cppt_phase_t phase;
    logic [16:0] cnt;
    logic        due;
    logic        out;
    logic [25:0] mc_cnt;
    logic [31:0] rdata;
  } cppt_state_t;

endpackage

/* hdl/cppt_hms.sv */
// Converts an hour/minute/second triple to seconds and checks its ranges.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module cppt_hms
  import cppt_pkg::*;
(
  // Time triple
  input  wire cppt_pkg::cppt_hms_t hms,
  // Result
  output logic [16:0]              secs,
  output logic                     ok
);
  always_comb begin
    secs = 17'(hms.hour * SEC_PER_HOUR) + 17'(hms.min * SEC_PER_MIN) + 17'(hms.sec);
    ok   = (hms.hour <= HOUR_MAX) && (hms.min <= MIN_MAX) && (hms.sec <= SEC_MAX);
  end
endmodule
`default_nettype wire

/* hdl/cppt_timer.sv */
// Calendar periodic pulse timer: register port, schedule anchoring,
// start/period count-up and the one-machine-cycle pulse output.
// Assumes the calendar source and register master share clk.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cppt_timer
  import cppt_pkg::*;
#(
  parameter int unsigned MC_Q_LEN = MC_Q_CYC,
  parameter int unsigned MC_H_LEN = MC_H_CYC,
  parameter int unsigned MC_F_LEN = MC_F_CYC
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Register port
  input  wire cppt_pkg::cppt_bus_t bus,
  output logic [31:0]              rdata,
  // Calendar source
  input  wire cppt_pkg::cppt_cal_t cal,
  // Outputs
  output logic                     periodic_pulse_out,
  output logic                     cfg_error
);
  import cppt_pkg::*;

  cppt_state_t s;
  cppt_state_t next_s;

  cppt_hms_t   cand_per;
  cppt_hms_t   cand_st;
  logic [4:0]  cand_day;
  logic [16:0] cand_per_sec;
  logic [16:0] cand_st_sec;
  logic        per_ok;
  logic        st_ok;
  logic        wr_per;
  logic        wr_st;
  logic        cfg_ok;
  logic [25:0] mc_last;
  logic        mc_tick;
  logic [4:0]  mday_target;
  logic        cal_anchor;
  logic        free_hold;

  cppt_hms u_per (
    .hms  (cand_per),
    .secs (cand_per_sec),
    .ok   (per_ok)
  );

  cppt_hms u_st (
    .hms  (cand_st),
    .secs (cand_st_sec),
    .ok   (st_ok)
  );

  // Candidate configuration: the word being written merged with what is held
  always_comb begin
    wr_per   = bus.wr && (bus.addr == ADDR_PERIOD);
    wr_st    = bus.wr && (bus.addr == ADDR_START);
    cand_per = s.per;
    cand_st  = s.st;
    cand_day = s.st_day;
    if (wr_per) begin
      cand_per.hour = bus.wdata[HOUR_LSB +: 5];
      cand_per.min  = bus.wdata[MIN_LSB +: 6];
      cand_per.sec  = bus.wdata[SEC_LSB +: 6];
    end
    if (wr_st) begin
      cand_st.hour = bus.wdata[HOUR_LSB +: 5];
      cand_st.min  = bus.wdata[MIN_LSB +: 6];
      cand_st.sec  = bus.wdata[SEC_LSB +: 6];
      cand_day     = bus.wdata[DAY_LSB +: 5];
    end
    // Whole-set check so a pair of writes can never leave start past period
    cfg_ok = per_ok && st_ok && (cand_day >= DAY_MIN) && (cand_day <= DAY_MAX)
             && (cand_st_sec <= cand_per_sec);
  end

  // Machine cycle length and calendar anchors
  always_comb begin
    case (s.mc_sel)
      2'h0:    mc_last = 26'(MC_Q_LEN - 1);
      2'h1:    mc_last = 26'(MC_H_LEN - 1);
      default: mc_last = 26'(MC_F_LEN - 1);
    endcase
    mc_tick     = (s.mc_cnt >= mc_last);                              // Shorter cycle must not strand the count
    mday_target = (s.st_day > cal.mdays) ? cal.mdays : s.st_day;
    cal_anchor  = 1'b0;
    if (cal.sec_tick && (cal.tod == '0)) begin
      case (s.fmt)
        CPPT_FMT_DAILY:   cal_anchor = 1'b1;
        CPPT_FMT_WEEKLY:  cal_anchor = ({2'h0, cal.wday} == s.st_day);
        CPPT_FMT_MONTHLY: cal_anchor = (cal.mday == mday_target);
        default:          cal_anchor = 1'b0;
      endcase
    end
    free_hold = (s.fmt == CPPT_FMT_NONE) && s.hold;
  end

  // Next state
  always_comb begin
    logic [16:0] c;
    cppt_phase_t ph;
    c      = '0;
    ph     = s.phase;
    next_s = s;

    // Register port: read data stand for one cycle only
    next_s.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL: begin
          next_s.rdata[FMT_LSB +: 2]   = s.fmt;
          next_s.rdata[MCSEL_LSB +: 2] = s.mc_sel;
          next_s.rdata[HOLD_BIT]       = s.hold;
        end
        ADDR_PERIOD: begin
          next_s.rdata[HOUR_LSB +: 5] = s.per.hour;
          next_s.rdata[MIN_LSB +: 6]  = s.per.min;
          next_s.rdata[SEC_LSB +: 6]  = s.per.sec;
        end
        ADDR_START: begin
          next_s.rdata[HOUR_LSB +: 5] = s.st.hour;
          next_s.rdata[MIN_LSB +: 6]  = s.st.min;
          next_s.rdata[SEC_LSB +: 6]  = s.st.sec;
          next_s.rdata[DAY_LSB +: 5]  = s.st_day;
        end
        ADDR_STATUS: begin
          next_s.rdata[ERR_BIT]         = s.err;
          next_s.rdata[OUT_BIT]         = s.out;
          next_s.rdata[PHASE_LSB +: 2]  = s.phase;
        end
        default: next_s.rdata = '0;
      endcase
    end

    // Machine cycle: the output shows the pending pulse for one whole cycle
    if (mc_tick) begin
      next_s.mc_cnt = '0;
      next_s.out    = s.due;
      next_s.due    = 1'b0;
    end else begin
      next_s.mc_cnt = 26'(s.mc_cnt + 26'h1);
    end

    // Second step: counts from anchor to start, then period to period
    if (cal.sec_tick) begin
      if (cal_anchor || (s.phase == CPPT_PH_ARM)) begin
        ph = CPPT_PH_TO_START;
        c  = '0;
      end else begin
        c  = 17'(s.cnt + 17'h1);
      end
      case (ph)
        CPPT_PH_TO_START: begin
          if (c == s.st_sec) begin
            next_s.due   = 1'b1;
            next_s.phase = CPPT_PH_REPEAT;
            next_s.cnt   = '0;
          end else begin
            next_s.phase = CPPT_PH_TO_START;
            next_s.cnt   = c;
          end
        end
        CPPT_PH_REPEAT: begin
          // A zero period gives a single pulse per anchor
          if (s.per_sec != '0) begin
            if (c == s.per_sec) begin
              next_s.due = 1'b1;
              next_s.cnt = '0;
            end else begin
              next_s.cnt = c;
            end
          end
        end
        default: next_s.cnt = s.cnt;
      endcase
    end

    // Register writes
    if (bus.wr && (bus.addr == ADDR_CTRL)) begin
      next_s.fmt    = cppt_fmt_t'(bus.wdata[FMT_LSB +: 2]);
      next_s.mc_sel = bus.wdata[MCSEL_LSB +: 2];
      next_s.hold   = bus.wdata[HOLD_BIT];
      if (cppt_fmt_t'(bus.wdata[FMT_LSB +: 2]) != s.fmt) begin
        next_s.phase = (bus.wdata[FMT_LSB +: 2] == 2'h0) ? CPPT_PH_ARM : CPPT_PH_IDLE;
        next_s.cnt   = '0;
      end
    end
    if (wr_per || wr_st) begin
      if (cfg_ok) begin
        next_s.per     = cand_per;
        next_s.per_sec = cand_per_sec;
        next_s.st      = cand_st;
        next_s.st_sec  = cand_st_sec;
        next_s.st_day  = cand_day;
        next_s.err     = 1'b0;
        next_s.phase   = (s.fmt == CPPT_FMT_NONE) ? CPPT_PH_ARM : CPPT_PH_IDLE;
        next_s.cnt     = '0;
      end else begin
        next_s.err     = 1'b1;
      end
    end

    // In the free-running format only, hold parks the timer in the arm phase with the output low
    if (free_hold) begin
      next_s.phase = CPPT_PH_ARM;
      next_s.cnt   = '0;
      next_s.due   = 1'b0;
      next_s.out   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s        <= '0;
      s.mc_sel <= MCSEL_RST;
      s.st_day <= DAY_RST;
      s.phase  <= CPPT_PH_ARM;
    end else begin
      s <= next_s;
    end
  end

  assign periodic_pulse_out = s.out;
  assign cfg_error          = s.err;
  assign rdata              = s.rdata;

  property p_pulse_len;
    @(posedge clk) disable iff (!rst_n)
      (s.out && !mc_tick && !free_hold) |=> s.out;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse dropped inside its machine cycle");

  property p_pulse_start;
    @(posedge clk) disable iff (!rst_n)
      (mc_tick && s.due && !free_hold) |=> s.out ##1 (s.out || $past(mc_tick) || $past(free_hold));
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("pending pulse not shown at machine cycle");

  property p_pulse_low;
    @(posedge clk) disable iff (!rst_n)
      (mc_tick && !s.due) |=> !s.out;
  endproperty
  a_pulse_low: assert property (p_pulse_low)
    else $error("pulse high without a pending event");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      free_hold |=> (!s.out && !s.due && (s.phase == CPPT_PH_ARM) && (s.cnt == '0));
  endproperty
  a_hold: assert property (p_hold)
    else $error("held timer not parked");

  property p_reject;
    @(posedge clk) disable iff (!rst_n)
      ((wr_per || wr_st) && (cand_st_sec > cand_per_sec))
        |=> (s.err && $stable(s.st_sec) && $stable(s.per_sec));
  endproperty
  a_reject: assert property (p_reject)
    else $error("start past period was accepted");

  property p_period_range;
    @(posedge clk) disable iff (!rst_n)
      (wr_per && (bus.wdata[HOUR_LSB +: 5] > HOUR_MAX)) |=> (s.err && (s.per.hour <= HOUR_MAX));
  endproperty
  a_period_range: assert property (p_period_range)
    else $error("period hour out of range accepted");

  property p_start_store;
    @(posedge clk) disable iff (!rst_n)
      (wr_st && cfg_ok) |=> (s.st_sec == $past(cand_st_sec)) && !s.err;
  endproperty
  a_start_store: assert property (p_start_store)
    else $error("valid start time not stored");

  property p_daily;
    @(posedge clk) disable iff (!rst_n)
      (cal.sec_tick && (cal.tod == '0) && (s.fmt == CPPT_FMT_DAILY) && !bus.wr)
        |=> (s.phase != CPPT_PH_IDLE) && (s.cnt == '0);
  endproperty
  a_daily: assert property (p_daily)
    else $error("daily schedule not anchored at midnight");

  property p_weekly;
    @(posedge clk) disable iff (!rst_n)
      (cal.sec_tick && (cal.tod == '0) && (s.fmt == CPPT_FMT_WEEKLY) && !bus.wr
        && ({2'h0, cal.wday} == s.st_day)) |=> (s.phase != CPPT_PH_IDLE);
  endproperty
  a_weekly: assert property (p_weekly)
    else $error("weekly schedule missed its weekday");

  property p_monthly;
    @(posedge clk) disable iff (!rst_n)
      (cal.sec_tick && (cal.tod == '0) && (s.fmt == CPPT_FMT_MONTHLY) && !bus.wr
        && (s.st_day > cal.mdays) && (cal.mday == cal.mdays)) |=> (s.phase != CPPT_PH_IDLE);
  endproperty
  a_monthly: assert property (p_monthly)
    else $error("monthly schedule missed the last day");

endmodule
`default_nettype wire

/* tb/cppt_testbench.sv */
// Self-checking testbench for the calendar periodic pulse timer.
// Assumes the timer is built with short machine cycles of 4, 8 and 16 clocks.
`timescale 1ns/1ps
`default_nettype none
`define check_eq(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, (got), (exp)); end end
module testbench;
  import cppt_pkg::*;

  localparam int unsigned QL    = 4;
  localparam int unsigned HL    = 8;
  localparam int unsigned FL    = 16;
  localparam int unsigned GAP   = 40;
  localparam int unsigned LIMIT = 10000;

  typedef struct {
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic        err;
    logic [7:0]  raddr;
    logic [31:0] mask;
    logic [31:0] exp;
  } cppt_reg_row_t;

  typedef struct {
    logic [1:0] fmt;
    logic       hold;
    logic [4:0] day;
    logic [2:0] wday;
    logic [4:0] mday;
    logic [4:0] mdays;
    int         first;
    int         exp;
  } cppt_cal_row_t;

  logic        clk;
  logic        rst_n;
  cppt_bus_t   bus;
  logic [31:0] rdata;
  cppt_cal_t   cal;
  logic        periodic_pulse_out;
  logic        cfg_error;
  logic [31:0] rd_val;
  int          mismatches;
  int          n_checks;
  int          pulses;
  int          run;
  int          last_run;
  int          high_total;
  int          cycles;
  int          lens[4] = '{QL, HL, FL, FL};

  // Refused writes must leave the held word untouched, so each but the bad-minute period write is read back
  cppt_reg_row_t regs[13] = '{
    '{8'h04, 32'h0003_0201, 1'b0, 8'h04, 32'h003F_3F1F, 32'h0003_0201},
    '{8'h04, 32'h0003_0218, 1'b1, 8'h04, 32'h003F_3F1F, 32'h0003_0201},
    '{8'h04, 32'h0003_3C01, 1'b1, 8'h0C, 32'h0000_0001, 32'h0000_0001},
    '{8'h04, 32'h003C_0201, 1'b1, 8'h04, 32'h003F_3F1F, 32'h0003_0201},
    '{8'h08, 32'h0105_0000, 1'b0, 8'h08, 32'h1F3F_3F1F, 32'h0105_0000},
    '{8'h08, 32'h0100_0002, 1'b1, 8'h08, 32'h1F3F_3F1F, 32'h0105_0000},
    '{8'h08, 32'h0103_0201, 1'b0, 8'h08, 32'h1F3F_3F1F, 32'h0103_0201},
    '{8'h08, 32'h0000_0000, 1'b1, 8'h08, 32'h1F3F_3F1F, 32'h0103_0201},
    '{8'h04, 32'h0003_0200, 1'b1, 8'h04, 32'h003F_3F1F, 32'h0003_0201},
    '{8'h08, 32'h1F00_0000, 1'b0, 8'h08, 32'h1F3F_3F1F, 32'h1F00_0000},
    '{8'h04, 32'h003B_3B17, 1'b0, 8'h04, 32'h003F_3F1F, 32'h003B_3B17},
    '{8'h10, 32'hFFFF_FFFF, 1'b0, 8'h10, 32'hFFFF_FFFF, 32'h0000_0000},
    '{8'h00, 32'h0000_001F, 1'b0, 8'h00, 32'h0000_001F, 32'h0000_001F}
  };

  // Anchor ticks run at seconds first, first+1, first+2 with a start of 0:0:2
  cppt_cal_row_t crow[11] = '{
    '{2'h1, 1'b0, 5'h01, 3'h1, 5'h01, 5'h1F, 0, 1},
    '{2'h1, 1'b0, 5'h01, 3'h1, 5'h01, 5'h1F, 5, 0},
    '{2'h1, 1'b1, 5'h01, 3'h1, 5'h01, 5'h1F, 0, 1},
    '{2'h2, 1'b0, 5'h03, 3'h3, 5'h01, 5'h1F, 0, 1},
    '{2'h2, 1'b0, 5'h03, 3'h2, 5'h01, 5'h1F, 0, 0},
    '{2'h2, 1'b0, 5'h07, 3'h7, 5'h01, 5'h1F, 0, 1},
    '{2'h2, 1'b0, 5'h01, 3'h1, 5'h01, 5'h1F, 0, 1},
    '{2'h3, 1'b0, 5'h1F, 3'h1, 5'h1E, 5'h1E, 0, 1},
    '{2'h3, 1'b0, 5'h1F, 3'h1, 5'h1D, 5'h1E, 0, 0},
    '{2'h3, 1'b0, 5'h0F, 3'h1, 5'h0F, 5'h1F, 0, 1},
    '{2'h3, 1'b0, 5'h1E, 3'h1, 5'h1C, 5'h1C, 0, 1}
  };

  cppt_timer #(
    .MC_Q_LEN(QL),
    .MC_H_LEN(HL),
    .MC_F_LEN(FL)
  ) dut_u (
    .clk               (clk),
    .rst_n             (rst_n),
    .bus               (bus),
    .rdata             (rdata),
    .cal               (cal),
    .periodic_pulse_out(periodic_pulse_out),
    .cfg_error         (cfg_error)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Pulse monitor: counts pulses, their length and every high cycle
  // Sampled on the falling edge so the output has settled after its launch edge
  always @(negedge clk) begin
    cycles++;
    if (rst_n === 1'b1 && periodic_pulse_out !== 1'b0 && periodic_pulse_out !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t pulse output unknown", $time);
    end
    if (periodic_pulse_out === 1'b1) begin
      if (run == 0)
        pulses++;
      run++;
      high_total++;
    end else if (run != 0) begin
      last_run = run;
      run = 0;
    end
    if (cycles == LIMIT) begin
      mismatches++;
      $display("[FAIL] %0t run did not finish in time", $time);
      complete_run();
    end
  end

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd   <= 1'b0;
    @(negedge clk);
    rd_val = rdata;
  endtask

  task automatic tick(input int s);
    @(posedge clk);
    cal.tod      <= '{5'h00, 6'h00, 6'(s)};
    cal.sec_tick <= 1'b1;
    @(posedge clk);
    cal.sec_tick <= 1'b0;
    repeat (GAP) @(posedge clk);
  endtask

  task automatic clear_counts();
    pulses = 0;
    high_total = 0;
    last_run = 0;
  endtask

  initial begin
    rst_n = 1'b0;
    bus = '0;
    cal = '0;
    cal.wday = 3'h1;
    cal.mday = 5'h01;
    cal.mdays = 5'h1F;
    rd_val = '0;
    {mismatches, n_checks, pulses, run, last_run, high_total, cycles} = '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    `check_eq(periodic_pulse_out, 1'b0)
    `check_eq(cfg_error, 1'b0)
    `check_eq(rdata, 32'h0)
    @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(ADDR_CTRL);
    `check_eq(rd_val & 32'h1F, 32'h08)
    bus_rd(ADDR_PERIOD);
    `check_eq(rd_val, 32'h0)
    bus_rd(ADDR_START);
    `check_eq(rd_val & 32'h1F3F_3F1F, 32'h0100_0000)
    bus_rd(ADDR_STATUS);
    `check_eq(rd_val & 32'h33, 32'h10)
    foreach (regs[i]) begin
      bus_wr(regs[i].waddr, regs[i].wdata);
      @(negedge clk);
      `check_eq(cfg_error, regs[i].err)
      bus_rd(regs[i].raddr);
      `check_eq(rd_val & regs[i].mask, regs[i].exp)
      @(negedge clk);
      `check_eq(rdata, 32'h0)
    end
    // Pulse length for every machine cycle choice, start 2 s, period 3 s
    bus_wr(ADDR_PERIOD, 32'h0003_0000);
    bus_wr(ADDR_START, 32'h0102_0000);
    for (int m = 0; m < 4; m++) begin
      bus_wr(ADDR_CTRL, 32'h10 | (32'(m) << 2));
      bus_wr(ADDR_CTRL, 32'(m) << 2);
      clear_counts();
      repeat (7) tick(0);
      `check_eq(pulses, 2)
      `check_eq(last_run, lens[m])
      `check_eq(high_total, 2 * lens[m])
    end
    // Hold keeps the output low, and a hold mid-count restarts the count to the start time
    bus_wr(ADDR_CTRL, 32'h18);
    clear_counts();
    repeat (5) tick(0);
    `check_eq(pulses, 0)
    `check_eq(high_total, 0)
    bus_wr(ADDR_CTRL, 32'h08);
    repeat (2) tick(0);
    bus_wr(ADDR_CTRL, 32'h18);
    bus_wr(ADDR_CTRL, 32'h08);
    repeat (2) tick(0);
    `check_eq(pulses, 0)
    tick(0);
    `check_eq(pulses, 1)
    // Calendar formats anchor only at midnight: daily each day, weekly and monthly on the chosen day, monthly clamped to the last day
    foreach (crow[i]) begin
      bus_wr(ADDR_CTRL, {27'h0, crow[i].hold, 2'h2, crow[i].fmt});
      bus_wr(ADDR_START, {3'h0, crow[i].day, 2'h0, 6'h02, 2'h0, 6'h00, 3'h0, 5'h00});
      @(posedge clk);
      cal.wday  <= crow[i].wday;
      cal.mday  <= crow[i].mday;
      cal.mdays <= crow[i].mdays;
      clear_counts();
      tick(crow[i].first);
      tick(crow[i].first + 1);
      tick(crow[i].first + 2);
      `check_eq(pulses, crow[i].exp)
    end
    // Reset in mid-run clears a standing error and keeps the output low
    bus_wr(ADDR_PERIOD, 32'h0000_0018);
    @(negedge clk);
    `check_eq(cfg_error, 1'b1)
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    `check_eq(cfg_error, 1'b0)
    `check_eq(periodic_pulse_out, 1'b0)
    @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(ADDR_CTRL);
    `check_eq(rd_val & 32'h1F, 32'h08)
    complete_run();
  end
endmodule
`default_nettype wire
